//--- rtl/mhr_params.svh
`ifndef MHR_PARAMS_SVH
`define MHR_PARAMS_SVH
// Record type code and flag positions
`define MHR_TYPE_CODE 7'h05
`define MHR_TYPE_EXT_BIT 7
`define MHR_FLG_IF_LSB 0
`define MHR_FLG_VLEN_BIT 2
`define MHR_FLG_TRUNC_BIT 3
`define MHR_FLG_RXERR_BIT 4
`define MHR_FLG_DSERR_BIT 5
// Per-channel header fields
`define MHR_PCH_CONN_LSB 0
`define MHR_PCH_FCS_BIT 24
`define MHR_PCH_SHORT_BIT 25
`define MHR_PCH_LONG_BIT 26
`define MHR_PCH_ABORT_BIT 27
`define MHR_PCH_OCTET_BIT 28
`define MHR_PCH_LOST_BIT 29
`define MHR_PCH_FIRST_BIT 30
`define MHR_PCH_ERR_LSB 24
`define MHR_PCH_ERR_MSB 29
// Length figures in bytes
`define MHR_HDR_BYTES 16'h0010
`define MHR_EXT_BYTES 16'h0008
`define MHR_PROTO_BYTES 16'h0008
`define MHR_HDLC_BYTES 16'h0004
`define MHR_SHORT_LIMIT 16'h0005
`define MHR_LONG_LIMIT 16'h07ff
// Register offsets
`define MHR_REG_CTRL 8'h00
`define MHR_REG_EXT_HI 8'h04
`define MHR_REG_EXT_LO 8'h08
`define MHR_REG_CONN_CFG 8'h0c
`define MHR_REG_IRQ_STAT 8'h10
`define MHR_REG_IRQ_MASK 8'h14
`define MHR_REG_REC_CNT 8'h18
`define MHR_REG_LAST_PCH 8'h1c
// Control bits and interrupt events
`define MHR_CTRL_EN_BIT 0
`define MHR_CTRL_EXT_BIT 1
`define MHR_CTRL_FOUR_BIT 2
`define MHR_IRQ_DONE_BIT 0
`define MHR_IRQ_ERR_BIT 1
`define MHR_IRQ_FIRST_BIT 2
// Reset values
`define MHR_CTRL_RST 3'h0
`define MHR_MASK_RST 3'h0
`endif

//--- rtl/mhr_pkg.sv
package mhr_pkg;
	// End-of-frame summary handed over by a channel receiver
	typedef struct packed {
		logic [9:0] conn_num;
		logic [9:0] vc_id;
		logic [1:0] port;
		logic [15:0] frame_len;
		logic fcs_err;
		logic abort_err;
		logic octet_err;
		logic lost_err;
		logic [31:0] hdlc_hdr;
	} mhr_frame_s;

	// Record stream word towards host memory
	typedef struct packed {
		logic [31:0] data;
		logic last;
	} mhr_word_s;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOAD,
		ST_EMIT
	} mhr_state_e;
endpackage : mhr_pkg

//--- rtl/mhr_record_builder.sv
`timescale 1ns/100ps
`include "mhr_params.svh"

module mhr_record_builder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frm_valid,
	output logic frm_ready,
	input wire mhr_pkg::mhr_frame_s frm,
	output logic rec_valid,
	input wire logic rec_ready,
	output mhr_pkg::mhr_word_s rec,
	output logic [15:0] rec_payload_len,
	output logic [1:0] rec_if_num,
	output logic irq
);
	mhr_pkg::mhr_state_e state_ff;
	mhr_pkg::mhr_state_e nxt_state;
	logic [2:0] ctrl_ff;
	logic [31:0] ext_hi_ff;
	logic [31:0] ext_lo_ff;
	logic [2:0] irq_stat_ff;
	logic [2:0] irq_mask_ff;
	logic [31:0] rec_cnt_ff;
	logic [31:0] last_pch_ff;
	logic [31:0] prdata_ff;
	logic [1023:0] first_pend_ff;
	logic [63:0] tstamp_ff;
	logic [63:0] rec_ts_ff;
	mhr_pkg::mhr_frame_s frm_ff;
	logic [31:0] pch_ff;
	logic [7:0] flags_ff;
	logic [15:0] rlen_ff;
	logic [15:0] pay_len_ff;
	logic [1:0] if_num_ff;
	logic ext_ff;
	logic [2:0] idx_ff;
	logic rec_valid_ff;
	mhr_pkg::mhr_word_s rec_ff;
	logic [15:0] payload_len;
	logic [15:0] rlen;
	logic [9:0] conn_sel;
	logic [31:0] pch;
	logic [7:0] flags;
	logic [2:0] last_idx;
	logic [31:0] word_mux;
	logic [2:0] events;
	logic wr_en;
	logic rd_setup;
	logic frm_take;
	logic word_adv;
	logic cfg_wr;

	// Zero wait states: read data is latched in the setup cycle
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign cfg_wr = wr_en && (paddr == `MHR_REG_CONN_CFG);
	assign prdata = prdata_ff;
	assign pslverr = psel & penable & (paddr > `MHR_REG_LAST_PCH | paddr[1:0] != 2'h0);

	// Frames are only accepted while idle and enabled; this stalls the receivers
	assign frm_ready = (state_ff == mhr_pkg::ST_IDLE) & ctrl_ff[`MHR_CTRL_EN_BIT];
	assign frm_take = frm_valid & frm_ready;
	assign word_adv = rec_valid_ff & rec_ready;

	assign rec_valid = rec_valid_ff;
	assign rec = rec_ff;
	assign rec_payload_len = pay_len_ff;
	assign rec_if_num = if_num_ff;
	assign irq = |(irq_stat_ff & irq_mask_ff);

	// Control and configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `MHR_CTRL_RST;
			ext_hi_ff <= 32'h0;
			ext_lo_ff <= 32'h0;
			irq_mask_ff <= `MHR_MASK_RST;
		end else if (wr_en) begin
			unique case (paddr)
				`MHR_REG_CTRL: ctrl_ff <= pwdata[2:0];
				`MHR_REG_EXT_HI: ext_hi_ff <= pwdata;
				`MHR_REG_EXT_LO: ext_lo_ff <= pwdata;
				`MHR_REG_IRQ_MASK: irq_mask_ff <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// Read data, captured in the setup cycle so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0;
		end else if (rd_setup) begin
			unique case (paddr)
				`MHR_REG_CTRL: prdata_ff <= {29'h0, ctrl_ff};
				`MHR_REG_EXT_HI: prdata_ff <= ext_hi_ff;
				`MHR_REG_EXT_LO: prdata_ff <= ext_lo_ff;
				`MHR_REG_IRQ_STAT: prdata_ff <= {29'h0, irq_stat_ff};
				`MHR_REG_IRQ_MASK: prdata_ff <= {29'h0, irq_mask_ff};
				`MHR_REG_REC_CNT: prdata_ff <= rec_cnt_ff;
				`MHR_REG_LAST_PCH: prdata_ff <= last_pch_ff;
				default: prdata_ff <= 32'h0;
			endcase
		end
	end

	// Sticky events; a new event wins over a write-one clear in the same cycle
	assign events[`MHR_IRQ_DONE_BIT] = word_adv & rec_ff.last;
	assign events[`MHR_IRQ_ERR_BIT] = word_adv & rec_ff.last & flags_ff[`MHR_FLG_RXERR_BIT];
	assign events[`MHR_IRQ_FIRST_BIT] = word_adv & rec_ff.last & pch_ff[`MHR_PCH_FIRST_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= 3'h0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~((wr_en && paddr == `MHR_REG_IRQ_STAT) ?
				pwdata[2:0] : 3'h0)) | events;
		end
	end

	// Capture time base and completed record count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tstamp_ff <= 64'h0;
			rec_cnt_ff <= 32'h0;
		end else begin
			tstamp_ff <= tstamp_ff + 64'h1;
			if (events[`MHR_IRQ_DONE_BIT]) begin
				rec_cnt_ff <= rec_cnt_ff + 32'h1;
			end
		end
	end

	// Connection field carries the VC identifier on the four-port card
	assign conn_sel = ctrl_ff[`MHR_CTRL_FOUR_BIT] ? frm.vc_id : frm.conn_num;

	// Per-channel header, reserved positions left zero
	always_comb begin
		pch = 32'h0;
		pch[`MHR_PCH_CONN_LSB +: 10] = conn_sel;
		pch[`MHR_PCH_FCS_BIT] = frm.fcs_err;
		pch[`MHR_PCH_SHORT_BIT] = frm.frame_len < `MHR_SHORT_LIMIT;
		pch[`MHR_PCH_LONG_BIT] = frm.frame_len > `MHR_LONG_LIMIT;
		pch[`MHR_PCH_ABORT_BIT] = frm.abort_err;
		pch[`MHR_PCH_OCTET_BIT] = frm.octet_err;
		pch[`MHR_PCH_LOST_BIT] = frm.lost_err;
		pch[`MHR_PCH_FIRST_BIT] = first_pend_ff[conn_sel];
	end

	// Flags byte: interface field zero, variable length, receive error from header
	always_comb begin
		flags = 8'h0;
		flags[`MHR_FLG_IF_LSB +: 2] = 2'h0;
		flags[`MHR_FLG_VLEN_BIT] = 1'b1;
		flags[`MHR_FLG_RXERR_BIT] = |pch[`MHR_PCH_ERR_MSB:`MHR_PCH_ERR_LSB];
	end

	// The frame's first bytes are the HDLC header; the rest is payload
	assign payload_len = (frm.frame_len > `MHR_HDLC_BYTES) ?
		frm.frame_len - `MHR_HDLC_BYTES : 16'h0;
	// Record length sums the parts, so the payload equals length minus headers
	assign rlen = `MHR_HDR_BYTES + (ctrl_ff[`MHR_CTRL_EXT_BIT] ? `MHR_EXT_BYTES : 16'h0) +
		`MHR_PROTO_BYTES + payload_len;

	// First-record marks: set by configuring a connection, consumed by its record.
	// A configuration in the same cycle as a record keeps the mark for the next one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_pend_ff <= '0;
		end else begin
			if (frm_take) begin
				first_pend_ff[conn_sel] <= 1'b0;
			end
			if (cfg_wr) begin
				first_pend_ff[pwdata[9:0]] <= 1'b1;
			end
		end
	end

	// Latch everything a record needs except the extension words when a frame is taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frm_ff <= '0;
			pch_ff <= 32'h0;
			flags_ff <= 8'h0;
			rlen_ff <= 16'h0;
			pay_len_ff <= 16'h0;
			if_num_ff <= 2'h0;
			ext_ff <= 1'b0;
			rec_ts_ff <= 64'h0;
			last_pch_ff <= 32'h0;
		end else if (frm_take) begin
			frm_ff <= frm;
			pch_ff <= pch;
			flags_ff <= flags;
			rlen_ff <= rlen;
			pay_len_ff <= payload_len;
			if_num_ff <= ctrl_ff[`MHR_CTRL_FOUR_BIT] ? frm.port : 2'h0;
			ext_ff <= ctrl_ff[`MHR_CTRL_EXT_BIT];
			rec_ts_ff <= tstamp_ff;
			last_pch_ff <= pch;
		end
	end

	// Word order: time stamp, type/flags/length, wire length, extension, headers
	assign last_idx = ext_ff ? 3'h7 : 3'h5;

	always_comb begin
		word_mux = 32'h0;
		unique case (idx_ff)
			3'h0: word_mux = rec_ts_ff[63:32];
			3'h1: word_mux = rec_ts_ff[31:0];
			3'h2: word_mux = {ext_ff, `MHR_TYPE_CODE, flags_ff, rlen_ff};
			3'h3: word_mux = {16'h0, frm_ff.frame_len};
			3'h4: word_mux = ext_ff ? ext_hi_ff : pch_ff;
			3'h5: word_mux = ext_ff ? ext_lo_ff : frm_ff.hdlc_hdr;
			3'h6: word_mux = pch_ff;
			3'h7: word_mux = frm_ff.hdlc_hdr;
		endcase
	end

	// Record sequencer
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			mhr_pkg::ST_IDLE: begin
				if (frm_take) begin
					nxt_state = mhr_pkg::ST_LOAD;
				end
			end
			mhr_pkg::ST_LOAD: nxt_state = mhr_pkg::ST_EMIT;
			mhr_pkg::ST_EMIT: begin
				if (word_adv && rec_ff.last) begin
					nxt_state = mhr_pkg::ST_IDLE;
				end
			end
			default: nxt_state = mhr_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= mhr_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Word index advances once in ST_LOAD, then only when the sink accepts, so the sink can stall us
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_ff <= 3'h0;
		end else if (state_ff == mhr_pkg::ST_IDLE) begin
			idx_ff <= 3'h0;
		end else if (state_ff == mhr_pkg::ST_LOAD || word_adv) begin
			idx_ff <= idx_ff + 3'h1;
		end
	end

	// Output word register, loaded from the mux at the index, which then moves one word ahead
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rec_valid_ff <= 1'b0;
			rec_ff <= '0;
		end else if (state_ff == mhr_pkg::ST_LOAD ||
			(state_ff == mhr_pkg::ST_EMIT && word_adv && !rec_ff.last)) begin
			rec_valid_ff <= 1'b1;
			rec_ff.data <= word_mux;
			rec_ff.last <= idx_ff == last_idx;
		end else if (word_adv) begin
			rec_valid_ff <= 1'b0;
			rec_ff.last <= 1'b0;
		end
	end
endmodule : mhr_record_builder

//--- sim/mhr_record_builder_monitor.sv
`timescale 1ns/100ps
// Checks record words from the block's ports alone
module mhr_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic frm_valid,
	input wire logic frm_ready,
	input wire logic rec_valid,
	input wire logic rec_ready,
	input wire mhr_pkg::mhr_word_s rec,
	input wire logic [15:0] rec_payload_len
);
	logic [2:0] idx_ff;
	logic ext_ff, rx_ff, pch, acc;
	logic [15:0] wl_ff;
	// Header slot moves by two when extension words are present
	assign acc = rec_valid && rec_ready;
	assign pch = rec_valid && idx_ff == (ext_ff ? 3'h6 : 3'h4);
	// Word slot, back to zero after the last word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			idx_ff <= 3'h0;
		else if (acc)
			idx_ff <= rec.last ? 3'h0 : idx_ff + 3'h1;
	end
	// Early fields kept, since the channel header comes later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_ff <= 1'b0;
			rx_ff <= 1'b0;
			wl_ff <= 16'h0;
		end else if (acc && idx_ff == 3'h2) begin
			ext_ff <= rec.data[31];
			rx_ff <= rec.data[20];
		end else if (acc && idx_ff == 3'h3) begin
			wl_ff <= rec.data[15:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence take_s; frm_valid && frm_ready; endsequence
	sequence head_s; rec_valid && idx_ff == 3'h2; endsequence
	sequence stall_s; rec_valid && !rec_ready; endsequence
	take_to_word_a: assert property (take_s |=> !rec_valid ##1 rec_valid)
		else $error("record late");
	type_code_a: assert property (head_s |-> rec.data[30:24] == 7'h05)
		else $error("bad type");
	cap_if_zero_a: assert property (head_s |-> rec.data[17:16] == 2'h0)
		else $error("interface not zero");
	var_len_a: assert property (head_s |-> rec.data[18])
		else $error("fixed length");
	rec_len_a: assert property (head_s |-> rec.data[15:0] ==
		16'h0018 + (rec.data[31] ? 16'h0008 : 16'h0) + rec_payload_len) else $error("bad rlen");
	rx_err_a: assert property (pch |-> rx_ff == (|rec.data[29:24]))
		else $error("rx error flag");
	resv_zero_a: assert property (pch |-> rec.data[23:10] == 14'h0 && !rec.data[31])
		else $error("reserved set");
	len_err_a: assert property (pch |-> rec.data[25] == (wl_ff < 16'h0005)
		&& rec.data[26] == (wl_ff > 16'h07ff)) else $error("length error bits");
	last_word_a: assert property (rec_valid |-> rec.last == (idx_ff == (ext_ff ? 3'h7 : 3'h5)))
		else $error("last misplaced");
	stall_hold_a: assert property (stall_s |=> rec_valid && $stable(rec))
		else $error("word dropped");
endmodule : mhr_chk

//--- sim/mhr_sink.sv
`timescale 1ns/100ps
// Host memory: stores record words, stalls in a varying pattern when slow
module mhr_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic rec_valid,
	input wire mhr_pkg::mhr_word_s rec,
	output logic rec_ready
);
	logic [31:0] q[$];
	int recs = 0;
	logic [2:0] lfsr_ff;
	// Ready moves only after an edge, as a real sink would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr_ff <= 3'h1;
			rec_ready <= 1'b0;
		end else begin
			lfsr_ff <= {lfsr_ff[1:0], lfsr_ff[2] ^ lfsr_ff[1]};
			rec_ready <= !slow || lfsr_ff[0];
		end
	end
	// Accepted words are stored; the last one closes the record.
	// Plain always, since the bench also empties the queue between records
	always @(posedge pclk) begin
		if (rec_valid && rec_ready) begin
			q.push_back(rec.data);
			if (rec.last)
				recs <= recs + 1;
		end
	end
endmodule : mhr_sink

//--- sim/tb_multichannel_hdlc_record_builder.sv
`timescale 1ns/100ps
module tb_multichannel_hdlc_record_builder;
	logic pclk, presetn, psel, penable, pwrite, frm_valid, slow, er, pready, pslverr;
	logic frm_ready, rec_valid, rec_ready, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, eh, el;
	logic [15:0] rec_payload_len;
	logic [1:0] rec_if_num;
	logic [2:0] ctl, stat;
	mhr_pkg::mhr_frame_s frm;
	mhr_pkg::mhr_word_s rec;
	logic [31:0] seed = 32'hb3b9;
	logic [15:0] lens [8] = '{16'h0004, 16'h0005, 16'h07ff, 16'h0800, 16'h0001, 16'h0000,
		16'h0040, 16'hffff};
	bit cfg [1024];
	int miscompares = 0;
	int total_checks = 0;
	int nrec = 0;
	mhr_record_builder uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .frm_valid, .frm_ready, .frm, .rec_valid, .rec_ready,
		.rec, .rec_payload_len, .rec_if_num, .irq);
	mhr_sink snk (.pclk, .presetn, .slow, .rec_valid, .rec, .rec_ready);
	// Capture clock, 20 ns period
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
			miscompares++;
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	// Mid-cycle sampling keeps the wait clear of edge races
	task automatic waitfor(input int k);
		int i;
		for (i = 0; i < 400; i++) begin
			@(negedge pclk);
			if (k == 0 ? frm_ready === 1'b1 : k == 1 ? snk.recs != nrec : pready === 1'b1)
				break;
		end
		if (i == 400) begin
			miscompares++;
			close_out();
		end
	endtask : waitfor
	// One APB transfer; the answer is taken at the edge that ends it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		waitfor(2);
		@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic setc(input logic [2:0] c);
		ctl = c;
		apb(1'b1, 8'h00, {29'h0, c});
	endtask : setc
	task automatic cfgc(input logic [9:0] c);
		cfg[c] = 1'b1;
		apb(1'b1, 8'h0c, {22'h0, c});
	endtask : cfgc
	// Hand over one frame, then compare the stored record with the model
	task automatic send(input logic [9:0] cn, input logic [15:0] len, input logic [3:0] e4);
		logic [31:0] h, pch, w2;
		logic [15:0] pay;
		logic [9:0] f;
		int n;
		h = rnd();
		f = ctl[2] ? ~cn : cn;
		pch = {1'b0, cfg[f], e4[3:1], len > 16'h07ff, len < 16'h0005, e4[0], 14'h0, f};
		cfg[f] = 1'b0;
		pay = len > 16'h0004 ? len - 16'h0004 : 16'h0;
		w2 = {ctl[1], 7'h05, 3'h0, |pch[29:24], 4'h4, 16'h0018 + {ctl[1], 3'h0} + pay};
		n = ctl[1] ? 8 : 6;
		stat |= {pch[30], |pch[29:24], 1'b1};
		@(posedge pclk);
		frm_valid <= 1'b1;
		frm <= '{cn, ~cn, h[1:0], len, e4[0], e4[1], e4[2], e4[3], h};
		waitfor(0);
		@(posedge pclk);
		frm_valid <= 1'b0;
		waitfor(1);
		nrec++;
		chk("words", 32'(n), 32'(snk.q.size()));
		chk("head", w2, snk.q[2]);
		chk("wire len", {16'h0, len}, snk.q[3]);
		chk("chan", pch, snk.q[n - 2]);
		chk("proto", h, snk.q[n - 1]);
		chk("pay", {16'h0, pay}, {16'h0, rec_payload_len});
		chk("port", {30'h0, ctl[2] ? h[1:0] : 2'h0}, {30'h0, rec_if_num});
		if (ctl[1]) begin
			chk("ext hi", eh, snk.q[4]);
			chk("ext lo", el, snk.q[5]);
		end
		snk.q.delete();
	endtask : send
	// Reset, then length and error sweep, modes, interrupt and bus errors
	initial begin
		{presetn, psel, penable, pwrite, frm_valid, slow} = 6'h0;
		{paddr, pwdata, ctl, stat} = 46'h0;
		frm = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 8'h14, 32'h7);
		setc(3'h1);
		cfgc(10'h5);
		for (int i = 0; i < 8; i++) begin
			if (i == 4)
				cfgc(10'h5);
			slow <= i[0];
			send(10'h5, lens[i], 4'(i * 5));
		end
		eh = rnd();
		el = rnd();
		apb(1'b1, 8'h04, eh);
		apb(1'b1, 8'h08, el);
		setc(3'h3);
		send(10'h3ff, 16'(rnd() & 32'h0fff), 4'h2);
		setc(3'h5);
		cfgc(10'h3f6);
		send(10'h9, 16'h0020, 4'h0);
		send(10'h9, 16'h0020, 4'h8);
		setc(3'h7);
		send(10'h200, 16'(rnd() & 32'h0fff), 4'h0);
		@(negedge pclk);
		chk("irq on", 32'h1, {31'h0, irq});
		apb(1'b0, 8'h10, 32'h0);
		chk("stat", {29'h0, stat}, rd);
		apb(1'b1, 8'h10, 32'h7);
		stat = 3'h0;
		@(negedge pclk);
		chk("irq off", 32'h0, {31'h0, irq});
		apb(1'b1, 8'h14, 32'h0);
		send(10'h1, 16'h0010, 4'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, 8'h14, 32'h1);
		@(negedge pclk);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		apb(1'b0, 8'h18, 32'h0);
		chk("rec cnt", 32'(nrec), rd);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		chk("unmapped rd", 32'h0, rd);
		// A refused write must leave control untouched
		apb(1'b1, 8'h01, 32'h0);
		chk("unaligned", 32'h1, {31'h0, er});
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl kept", {29'h0, ctl}, rd);
		// Last record went out on connection field ~1 in four-port mode, no errors
		apb(1'b0, 8'h1c, 32'h0);
		chk("last pch", 32'h000003fe, rd);
		close_out();
	end
endmodule : tb_multichannel_hdlc_record_builder
bind mhr_record_builder mhr_chk chk_i (.pclk(pclk), .presetn(presetn), .frm_valid(frm_valid),
	.frm_ready(frm_ready), .rec_valid(rec_valid), .rec_ready(rec_ready), .rec(rec),
	.rec_payload_len(rec_payload_len));
